// ---- verilog/vdrp_pkg.sv ----
// Functional notes
// - Transfer pin at row strobe fall: high means access, low means transfer.
// - Eight row bits at row fall, eight column bits at column fall.
// - Write pin low at row fall selects masked write, high for normal.
// - Mask returns to all ones; fresh mask is given each masked write.
// - Controller refreshes all 256 rows within every 4 ms.
// - Transfer pin held high at row fall for both refresh kinds.
// - Array-to-buffer completes by raising transfer pin while strobes low.
package vdrp_pkg;
   localparam int          CLK_HZ          = 20000000;
   localparam int          REFRESH_MS      = 4;
   localparam int          REFRESH_ROWS    = 256;
   localparam longint      REFRESH_CYCLES  =
      (longint'(CLK_HZ) / 1000 * REFRESH_MS) / REFRESH_ROWS;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 4;
   localparam int          FIFO_DEPTH      = 16;
   localparam logic [3:0]  MASK_RESET      = 4'hf;
   localparam int          PHASE_CYCLES    = 2;
   localparam int          SHIFT_HALF      = 1;
   // Command codes
   localparam logic [2:0]  CMD_READ        = 3'h0;
   localparam logic [2:0]  CMD_WRITE       = 3'h1;
   localparam logic [2:0]  CMD_MWRITE      = 3'h2;
   localparam logic [2:0]  CMD_XFER_RD     = 3'h3;
   localparam logic [2:0]  CMD_XFER_WR     = 3'h4;
   localparam logic [2:0]  CMD_SER_IN      = 3'h5;
   localparam logic [2:0]  CMD_ROW_REF     = 3'h6;
   localparam logic [2:0]  CMD_CBR_REF     = 3'h7;
   typedef enum logic [2:0]
   {
      VDRP_IDLE  = 3'b000,
      VDRP_ROW   = 3'b001,
      VDRP_COLAD = 3'b011,
      VDRP_COL   = 3'b010,
      VDRP_DONE  = 3'b110,
      VDRP_PRE   = 3'b111,
      VDRP_CBR   = 3'b101
   } vdrp_state_t;
endpackage : vdrp_pkg

// ---- verilog/vdrp_fifo.sv ----
`timescale 1ns/1ps
module vdrp_fifo
   import vdrp_pkg::*;
#(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
)
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             inValid,
   output      logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   output      logic             outValid,
   input  wire logic             outReady,
   output      logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   wire              doWr = inValid && inReady && ce;
   wire              doRd = outValid && outReady && ce;
   assign inReady  = (count_r != (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData  = mem[rdPtr_r];
   always_ff @(posedge mclk)
   begin
      if (doWr)
         mem[wrPtr_r] <= inData;
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else if (ce)
      begin
         if (doWr)
            wrPtr_r <= wrPtr_r + 1'b1;
         if (doRd)
            rdPtr_r <= rdPtr_r + 1'b1;
         if (doWr && !doRd)
            count_r <= count_r + 1'b1;
         else if (doRd && !doWr)
            count_r <= count_r - 1'b1;
      end
   end
endmodule : vdrp_fifo

// ---- verilog/vdrp_refresh_timer.sv ----
`timescale 1ns/1ps
module vdrp_refresh_timer
   import vdrp_pkg::*;
#(
   parameter int INTERVAL = int'(REFRESH_CYCLES)
)
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic served,
   output      logic due
);
   logic [15:0] cnt_r;
   logic        due_r;
   assign due = due_r;
   // Set wins over the clear when both land together
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         due_r <= 1'b0;
      end
      else if (ce)
      begin
         if (cnt_r == 16'(INTERVAL - 1))
         begin
            cnt_r <= '0;
            due_r <= 1'b1;
         end
         else
         begin
            cnt_r <= cnt_r + 16'h1;
            if (served)
               due_r <= 1'b0;
         end
      end
   end
endmodule : vdrp_refresh_timer

// ---- verilog/vdrp_host.sv ----
`timescale 1ns/1ps
module vdrp_host
   import vdrp_pkg::*;
#(
   parameter int REF_INTERVAL = int'(REFRESH_CYCLES)
)
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              cmdValid,
   output      logic              cmdReady,
   input  wire logic [2:0]        cmdOp,
   input  wire logic [ADDR_W-1:0] cmdRow,
   input  wire logic [ADDR_W-1:0] cmdCol,
   input  wire logic [DATA_W-1:0] cmdData,
   input  wire logic [DATA_W-1:0] cmdMask,
   input  wire logic              cmdPage,
   output      logic              rdValid,
   output      logic [DATA_W-1:0] rdData,
   input  wire logic              serInValid,
   output      logic              serInReady,
   input  wire logic [DATA_W-1:0] serInData,
   input  wire logic              serOutReady,
   output      logic              serOutValid,
   output      logic [DATA_W-1:0] serOutData,
   output      logic              serialIsInput,
   output      logic              row_strobe_n,
   output      logic              col_strobe_n,
   output      logic              transfer_output_enable_n,
   output      logic              mask_write_enable_n,
   output      logic [ADDR_W-1:0] mux_addr,
   input  wire logic [DATA_W-1:0] rand_data_in,
   output      logic [DATA_W-1:0] rand_data_out,
   output      logic              rand_data_oe,
   output      logic              shift_clock,
   output      logic              shift_port_gate_n,
   input  wire logic [DATA_W-1:0] shift_data_in,
   output      logic [DATA_W-1:0] shift_data_out,
   output      logic              shift_data_oe
);
   vdrp_state_t       state_r;
   vdrp_state_t       state_nxt;
   logic [2:0]        op_r;
   logic [ADDR_W-1:0] row_r;
   logic [ADDR_W-1:0] col_r;
   logic [DATA_W-1:0] data_r;
   logic [DATA_W-1:0] mask_r;
   logic              page_r;
   logic [3:0]        tmr_r;
   logic              rasN_r;
   logic              casN_r;
   logic              trN_r;
   logic              weN_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] dqOut_r;
   logic              dqOe_r;
   logic              rdValid_r;
   logic [DATA_W-1:0] rdData_r;
   logic              ready_r;
   logic              serIn_r;
   logic              sc_r;
   logic              seN_r;
   logic [DATA_W-1:0] sdqOut_r;
   logic              sdqOe_r;
   logic [DATA_W-1:0] dqSync1_r;
   logic [DATA_W-1:0] dqSync2_r;
   logic [DATA_W-1:0] sdqSync1_r;
   logic [DATA_W-1:0] sdqSync2_r;
   logic [1:0]        scTmr_r;
   logic              refDue;
   logic              refServed;
   logic              txValid;
   logic              txReady;
   logic [DATA_W-1:0] txData;
   logic              rxReady;

   function automatic logic isWriteOp(input logic [2:0] op);
      isWriteOp = (op == CMD_WRITE) || (op == CMD_MWRITE);
   endfunction : isWriteOp

   function automatic logic isXferOp(input logic [2:0] op);
      isXferOp = (op == CMD_XFER_RD) || (op == CMD_XFER_WR) ||
                 (op == CMD_SER_IN);
   endfunction : isXferOp

   wire phaseDone  = (tmr_r == 4'(PHASE_CYCLES - 1));
   // A raised ready is always honoured; a due refresh waits one command
   wire startCmd   = cmdValid && ready_r;
   wire startRef   = refDue && (state_r == VDRP_IDLE) && !startCmd;
   // Command fields as seen on the edge that opens a phase
   wire [2:0]        opNow   = (state_r == VDRP_IDLE) ? cmdOp : op_r;
   wire [ADDR_W-1:0] rowNow  = (state_r == VDRP_IDLE) ? cmdRow : row_r;
   wire [DATA_W-1:0] maskNow = (state_r == VDRP_IDLE) ? cmdMask : mask_r;
   wire [ADDR_W-1:0] colNow  = (state_r == VDRP_DONE) ? cmdCol : col_r;
   wire [DATA_W-1:0] dataNow = (state_r == VDRP_DONE) ? cmdData : data_r;
   wire rxFlush    = (state_r == VDRP_PRE) && (op_r == CMD_XFER_RD);
   wire pageGo     = cmdValid && page_r && (cmdOp == op_r) &&
                     !isXferOp(cmdOp) && (cmdRow == row_r) && !refDue;
   wire needsCol   = (op_r != CMD_ROW_REF);
   wire scRise     = (scTmr_r == 2'(SHIFT_HALF)) && !sc_r && !seN_r;
   wire serialBusy = (state_r != VDRP_IDLE) && isXferOp(op_r);
   // Serial shift pauses around every transfer cycle
   wire serialRun  = !serialBusy &&
                     (serIn_r ? txValid : rxReady);
   assign refServed = (state_r == VDRP_PRE) &&
                      (op_r == CMD_ROW_REF || op_r == CMD_CBR_REF);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         VDRP_IDLE:
            if (startRef || startCmd)
               state_nxt = (startRef) ? VDRP_CBR : VDRP_ROW;
         VDRP_ROW:
            if (phaseDone)
               state_nxt = needsCol ? VDRP_COLAD : VDRP_DONE;
         VDRP_COLAD:
            if (phaseDone)
               state_nxt = VDRP_COL;
         VDRP_COL:
            if (phaseDone)
               state_nxt = VDRP_DONE;
         VDRP_DONE:
            if (phaseDone)
               state_nxt = pageGo ? VDRP_COLAD : VDRP_PRE;
         VDRP_PRE:
            if (phaseDone)
               state_nxt = VDRP_IDLE;
         VDRP_CBR:
            if (phaseDone)
               state_nxt = VDRP_DONE;
         default:
            state_nxt = VDRP_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_r <= VDRP_IDLE;
         tmr_r   <= '0;
      end
      else if (ce)
      begin
         state_r <= state_nxt;
         tmr_r   <= (state_nxt != state_r) ? 4'h0 : tmr_r + 4'h1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         op_r   <= CMD_READ;
         row_r  <= '0;
         col_r  <= '0;
         data_r <= '0;
         mask_r <= MASK_RESET;
         page_r <= 1'b0;
      end
      else if (ce)
      begin
         if (state_r == VDRP_IDLE && startRef)
            op_r <= CMD_CBR_REF;
         else if ((state_r == VDRP_IDLE && startCmd) ||
                  (state_r == VDRP_DONE && phaseDone && pageGo))
         begin
            op_r   <= cmdOp;
            row_r  <= cmdRow;
            col_r  <= cmdCol;
            data_r <= cmdData;
            mask_r <= cmdMask;
            page_r <= cmdPage;
         end
      end
   end

   // Pin drive per phase
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rasN_r  <= 1'b1;
         casN_r  <= 1'b1;
         trN_r   <= 1'b1;
         weN_r   <= 1'b1;
         addr_r  <= '0;
         dqOut_r <= '0;
         dqOe_r  <= 1'b0;
      end
      else if (ce)
      begin
         case (state_nxt)
            VDRP_ROW:
            begin
               addr_r  <= rowNow;
               trN_r   <= !isXferOp(opNow);
               weN_r   <= !((opNow == CMD_MWRITE) ||
                           (opNow == CMD_XFER_WR) ||
                           (opNow == CMD_SER_IN));
               dqOut_r <= maskNow;
               dqOe_r  <= (opNow == CMD_MWRITE);
               rasN_r  <= !(tmr_r == 4'h0 && state_r == VDRP_ROW);
            end
            VDRP_COLAD:
            begin
               rasN_r  <= 1'b0;
               casN_r  <= 1'b1;
               addr_r  <= colNow;
               trN_r   <= !isXferOp(op_r) || (op_r == CMD_XFER_RD);
               weN_r   <= !isWriteOp(op_r);
               dqOut_r <= dataNow;
               dqOe_r  <= isWriteOp(op_r);
            end
            VDRP_COL:
            begin
               casN_r  <= 1'b0;
               // Read transfer holds transfer pin low to be raised later
               trN_r   <= (op_r == CMD_XFER_RD) ? 1'b0 :
                          (op_r == CMD_READ) ? 1'b0 : 1'b1;
            end
            VDRP_DONE:
            begin
               trN_r   <= 1'b1;
               dqOe_r  <= 1'b0;
               if (state_r == VDRP_CBR)
                  rasN_r <= 1'b0;
            end
            VDRP_CBR:
            begin
               casN_r  <= 1'b0;
               trN_r   <= 1'b1;
            end
            default:
            begin
               rasN_r  <= 1'b1;
               casN_r  <= 1'b1;
               trN_r   <= 1'b1;
               weN_r   <= 1'b1;
               dqOe_r  <= 1'b0;
            end
         endcase
         if (state_nxt == VDRP_ROW && state_r == VDRP_IDLE)
            rasN_r <= 1'b1;
         else if (state_r == VDRP_ROW && !phaseDone)
            rasN_r <= 1'b0;
      end
   end

   // Read data sampled from synchronised bus as the done phase opens
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         dqSync1_r <= '0;
         dqSync2_r <= '0;
         rdValid_r <= 1'b0;
         rdData_r  <= '0;
         ready_r   <= 1'b0;
      end
      else if (ce)
      begin
         dqSync1_r <= rand_data_in;
         dqSync2_r <= dqSync1_r;
         rdValid_r <= (state_r == VDRP_DONE) && (tmr_r == 4'h0) &&
                      (op_r == CMD_READ);
         if ((state_r == VDRP_DONE) && (tmr_r == 4'h0))
            rdData_r <= dqSync2_r;
         ready_r   <= (state_nxt == VDRP_IDLE) && !refDue &&
                      !(cmdValid && ready_r);
      end
   end

   // Serial side: mode, shift clock and data
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         serIn_r    <= 1'b0;
         sc_r       <= 1'b0;
         scTmr_r    <= '0;
         seN_r      <= 1'b1;
         sdqOut_r   <= '0;
         sdqOe_r    <= 1'b0;
         sdqSync1_r <= '0;
         sdqSync2_r <= '0;
      end
      else if (ce)
      begin
         sdqSync1_r <= shift_data_in;
         sdqSync2_r <= sdqSync1_r;
         if (state_r == VDRP_PRE && op_r == CMD_XFER_RD)
            serIn_r <= 1'b0;
         else if (state_r == VDRP_PRE &&
                  (op_r == CMD_XFER_WR || op_r == CMD_SER_IN))
            serIn_r <= 1'b1;
         if (state_nxt == VDRP_ROW && isXferOp(opNow))
            seN_r <= (opNow == CMD_SER_IN);
         else if (serialRun)
            seN_r <= 1'b0;
         else if (!serialBusy && serIn_r)
            seN_r <= 1'b1;
         sdqOe_r <= serIn_r && serialRun;
         // Next word settles while the shift clock is low
         if (!sc_r)
            sdqOut_r <= txData;
         if (serialRun)
         begin
            scTmr_r <= scTmr_r + 2'h1;
            if (scRise)
            begin
               sc_r     <= 1'b1;
               scTmr_r  <= '0;
            end
            else if (scTmr_r == 2'(SHIFT_HALF))
            begin
               sc_r    <= 1'b0;
               scTmr_r <= '0;
            end
         end
         else
            sc_r <= 1'b0;
      end
   end

   // One word each shift clock rise; four bits per row lane
   assign txReady = serialRun && serIn_r && scRise;

   vdrp_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_txFifo (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .inValid  (serInValid),
      .inReady  (serInReady),
      .inData   (serInData),
      .outValid (txValid),
      .outReady (txReady),
      .outData  (txData)
   );

   vdrp_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rxFifo (
      .mclk     (mclk),
      .rst      (rst || rxFlush),
      .ce       (ce),
      .inValid  (!serIn_r && serialRun && scRise),
      .inReady  (rxReady),
      .inData   (sdqSync2_r),
      .outValid (serOutValid),
      .outReady (serOutReady),
      .outData  (serOutData)
   );

   vdrp_refresh_timer #(
      .INTERVAL (REF_INTERVAL)
   ) u_refTimer (
      .mclk   (mclk),
      .rst    (rst),
      .ce     (ce),
      .served (refServed),
      .due    (refDue)
   );

   assign cmdReady                 = ready_r;
   assign rdValid                  = rdValid_r;
   assign rdData                   = rdData_r;
   assign serialIsInput            = serIn_r;
   assign row_strobe_n             = rasN_r;
   assign col_strobe_n             = casN_r;
   assign transfer_output_enable_n = trN_r;
   assign mask_write_enable_n      = weN_r;
   assign mux_addr                 = addr_r;
   assign rand_data_out            = dqOut_r;
   assign rand_data_oe             = dqOe_r;
   assign shift_clock              = sc_r;
   assign shift_port_gate_n        = seN_r;
   assign shift_data_out           = sdqOut_r;
   assign shift_data_oe            = sdqOe_r;
endmodule : vdrp_host

// ---- test/vdrp_host_properties.sv ----
`timescale 1ns/1ps
module vdrp_host_properties
   import vdrp_pkg::*;
#(
   parameter int REF_INTERVAL = 40
)
(
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              row_strobe_n,
   input wire logic              col_strobe_n,
   input wire logic              transfer_output_enable_n,
   input wire logic              mask_write_enable_n,
   input wire logic [ADDR_W-1:0] mux_addr,
   input wire logic              rand_data_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic [15:0] gapR;
   // Cycles since the row strobe was last low
   always_ff @(posedge mclk)
   begin
      if (rst || !row_strobe_n)
         gapR <= 16'h0000;
      else
         gapR <= gapR + 16'h0001;
   end
   AST_MASK_ON_BUS: assert property (
      $fell(row_strobe_n) && col_strobe_n && $past(transfer_output_enable_n)
      && !$past(mask_write_enable_n) |-> $past(rand_data_oe))
      else $error("mask not driven at row strobe");
   AST_WRITE_DATA: assert property (
      $fell(col_strobe_n) && !row_strobe_n && !$past(mask_write_enable_n)
      && $past(transfer_output_enable_n) |-> $past(rand_data_oe))
      else $error("write data not driven at column strobe");
   AST_READ_RELEASE: assert property (
      !row_strobe_n && !col_strobe_n && !transfer_output_enable_n
      |-> !rand_data_oe)
      else $error("host drives data while device may drive");
   AST_ROW_ADDR: assert property (
      $fell(row_strobe_n) && col_strobe_n
      |-> mux_addr == $past(mux_addr))
      else $error("row address moved at row strobe");
   AST_COL_ADDR: assert property (
      $fell(col_strobe_n) && !row_strobe_n
      |-> $past(mux_addr, 1) == $past(mux_addr, 2))
      else $error("column address moved at column strobe");
   AST_CBR_TR: assert property (
      $fell(row_strobe_n) && !col_strobe_n
      |-> $past(transfer_output_enable_n))
      else $error("transfer pin low at refresh row strobe");
   AST_XFER_FIRE: assert property (
      $fell(row_strobe_n) && !$past(transfer_output_enable_n)
      && $past(mask_write_enable_n) |-> ##[1:40]
      ($rose(transfer_output_enable_n) && !row_strobe_n && !col_strobe_n))
      else $error("read transfer not fired with strobes low");
   AST_REFRESH_GAP: assert property (
      gapR <= 16'(REF_INTERVAL + 40))
      else $error("row strobe idle beyond refresh interval");
endmodule : vdrp_host_properties

// ---- test/vdrp_vram_model.sv ----
`timescale 1ns/1ps
module vdrp_vram_model
   import vdrp_pkg::*;
(
   input  wire logic              row_strobe_n,
   input  wire logic              col_strobe_n,
   input  wire logic              transfer_output_enable_n,
   input  wire logic              mask_write_enable_n,
   input  wire logic [ADDR_W-1:0] mux_addr,
   input  wire logic [DATA_W-1:0] randBus,
   output      logic [DATA_W-1:0] randDrv,
   output      logic              randOe,
   input  wire logic              shift_clock,
   input  wire logic              shift_port_gate_n,
   input  wire logic [DATA_W-1:0] shiftBus,
   output      logic [DATA_W-1:0] shiftDrv,
   output      logic              shiftOe
);
   logic [DATA_W-1:0] mem [0:65535];
   logic [DATA_W-1:0] lineBuf [0:255];
   logic [7:0]        rowR, colR, tapR, serAddr, cbrRow;
   logic [3:0]        maskR;
   logic              xferR, toArrR, gateR, inMode;
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 4'(i >> 8) ^ 4'(i) ^ 4'(i >> 4);
      {rowR, colR, tapR, serAddr, cbrRow} = 40'h0;
      {xferR, toArrR, gateR, inMode} = 4'h0;
      maskR = 4'hf;
   end
   always @(negedge row_strobe_n)
   begin
      if (!col_strobe_n)
         cbrRow <= cbrRow + 8'h01;
      else
      begin
         rowR   <= mux_addr;
         xferR  <= !transfer_output_enable_n;
         toArrR <= !mask_write_enable_n;
         gateR  <= shift_port_gate_n;
         if (transfer_output_enable_n && !mask_write_enable_n)
            maskR <= randBus;
      end
   end
   always @(posedge row_strobe_n)
      maskR <= 4'hf;
   // Each column fall while the row is open is one access
   always @(negedge col_strobe_n)
   begin
      if (!row_strobe_n)
      begin
         colR <= mux_addr;
         if (xferR)
         begin
            tapR <= mux_addr;
            if (toArrR)
            begin
               serAddr <= mux_addr;
               inMode  <= 1'b1;
               if (!gateR)
                  for (int j = 0; j < 256; j++)
                     mem[{rowR, 8'(j)}] <= lineBuf[j];
            end
         end
         else if (!mask_write_enable_n)
            mem[{rowR, mux_addr}] <= (mem[{rowR, mux_addr}] & ~maskR)
                                     | (randBus & maskR);
      end
   end
   always @(posedge transfer_output_enable_n)
   begin
      if (!row_strobe_n && !col_strobe_n && xferR && !toArrR)
      begin
         for (int j = 0; j < 256; j++)
            lineBuf[j] <= mem[{rowR, 8'(j)}];
         serAddr <= tapR;
         inMode  <= 1'b0;
      end
   end
   always @(posedge shift_clock)
   begin
      if (inMode && !shift_port_gate_n)
         lineBuf[serAddr] <= shiftBus;
      serAddr <= serAddr + 8'h01;
   end
   assign randOe   = !transfer_output_enable_n && !row_strobe_n
                     && !col_strobe_n && !xferR;
   assign randDrv  = mem[{rowR, colR}];
   assign shiftOe  = !inMode && !shift_port_gate_n;
   assign shiftDrv = lineBuf[serAddr];
endmodule : vdrp_vram_model

// ---- test/vdrp_host_bench.sv ----
`timescale 1ns/1ps
module vdrp_host_bench;
   import vdrp_pkg::*;
   localparam int REF_INT = 40;
   localparam int CEIL    = 20000;
   logic              mclk, rst, cmdValid, cmdReady, rdValid;
   logic [2:0]        cmdOp;
   logic [ADDR_W-1:0] cmdRow, cmdCol, mux_addr;
   logic [DATA_W-1:0] cmdData, cmdMask, rdData, serInData, serOutData;
   logic              serInValid, serInReady, serOutReady, serOutValid;
   logic              serialIsInput, row_strobe_n, col_strobe_n;
   logic              transfer_output_enable_n, mask_write_enable_n;
   logic [DATA_W-1:0] hostOut, devOut, randBus, randLast;
   logic [DATA_W-1:0] shHostOut, shDevOut, shiftBus, shiftLast;
   logic              hostOe, devOe, shHostOe, shDevOe;
   logic              shift_clock, shift_port_gate_n;
   int                fails, n_checks, cycles;
   vdrp_host #(.REF_INTERVAL(REF_INT)) i_dut (
      .mclk, .rst, .ce(1'b1), .cmdValid, .cmdReady, .cmdOp, .cmdRow,
      .cmdCol, .cmdData, .cmdMask, .cmdPage(1'b0), .rdValid, .rdData,
      .serInValid, .serInReady, .serInData, .serOutReady, .serOutValid,
      .serOutData, .serialIsInput, .row_strobe_n, .col_strobe_n,
      .transfer_output_enable_n, .mask_write_enable_n, .mux_addr,
      .rand_data_in(randBus), .rand_data_out(hostOut), .rand_data_oe(hostOe),
      .shift_clock, .shift_port_gate_n, .shift_data_in(shiftBus),
      .shift_data_out(shHostOut), .shift_data_oe(shHostOe));
   vdrp_vram_model i_vram (
      .row_strobe_n, .col_strobe_n, .transfer_output_enable_n,
      .mask_write_enable_n, .mux_addr, .randBus, .randDrv(devOut),
      .randOe(devOe), .shift_clock, .shift_port_gate_n, .shiftBus,
      .shiftDrv(shDevOut), .shiftOe(shDevOe));
   // Released lines toggle so a stale value never reads as valid
   assign randBus  = hostOe ? hostOut : (devOe ? devOut : ~randLast);
   assign shiftBus = shHostOe ? shHostOut : (shDevOe ? shDevOut : ~shiftLast);
   always #25 mclk = ~mclk;
   always @(posedge mclk)
   begin
      randLast  <= randBus;
      shiftLast <= shiftBus;
      cycles    <= cycles + 1;
      if (cycles == CEIL)
      begin
         fails++;
         close_out();
      end
   end
   task automatic close_out();
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   task automatic check_word(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : check_word
   task automatic check_count(input int got, input int exp);
      n_checks++;
      if (got != exp)
      begin
         fails++;
         $display("Error at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask : check_count
   function automatic logic [3:0] pat(input logic [7:0] r, input logic [7:0] c);
      return r[3:0] ^ c[3:0] ^ c[7:4];
   endfunction : pat
   task automatic cmd(input logic [2:0] op, input logic [7:0] r, c,
                      input logic [3:0] d, m);
      int n;
      n = 0;
      cmdValid = 1'b1;
      {cmdOp, cmdRow, cmdCol, cmdData, cmdMask} = {op, r, c, d, m};
      while (cmdReady !== 1'b1 && n < 500)
      begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      cmdValid = 1'b0;
      @(negedge mclk);
   endtask : cmd
   task automatic rd_check(input logic [7:0] r, c, input logic [3:0] exp);
      int n;
      n = 0;
      cmd(CMD_READ, r, c, 4'h0, 4'hf);
      while (rdValid !== 1'b1 && n < 100)
      begin
         @(negedge mclk);
         n++;
      end
      check_word(rdData, exp);
   endtask : rd_check
   task automatic t_access();
      cmd(CMD_WRITE, 8'h12, 8'h34, 4'ha, 4'hf);
      cmd(CMD_WRITE, 8'h12, 8'h35, 4'h5, 4'hf);
      rd_check(8'h12, 8'h34, 4'ha);
      rd_check(8'h12, 8'h35, 4'h5);
      rd_check(8'h21, 8'h43, pat(8'h21, 8'h43));
   endtask : t_access
   task automatic t_masked();
      cmd(CMD_MWRITE, 8'h12, 8'h34, 4'h0, 4'h6);
      rd_check(8'h12, 8'h34, 4'h8);
      cmd(CMD_MWRITE, 8'h12, 8'h34, 4'hf, 4'h1);
      rd_check(8'h12, 8'h34, 4'h9);
      cmd(CMD_WRITE, 8'h12, 8'h35, 4'h0, 4'h0);
      rd_check(8'h12, 8'h35, 4'h0);
   endtask : t_masked
   task automatic t_refresh();
      cmd(CMD_ROW_REF, 8'h12, 8'h00, 4'h0, 4'hf);
      cmd(CMD_CBR_REF, 8'h00, 8'h00, 4'h0, 4'hf);
      repeat (3 * REF_INT) @(negedge mclk);
      rd_check(8'h12, 8'h34, 4'h9);
   endtask : t_refresh
   task automatic t_xfer_rd();
      int n;
      cmd(CMD_XFER_RD, 8'h05, 8'hfe, 4'h0, 4'hf);
      repeat (60) @(negedge mclk);
      check_word({3'h0, serialIsInput}, 4'h0);
      for (int k = 0; k < FIFO_DEPTH; k++)
      begin
         n = 0;
         while (serOutValid !== 1'b1 && n < 100)
         begin
            @(negedge mclk);
            n++;
         end
         check_word(serOutData, pat(8'h05, 8'(8'hfe + k)));
         serOutReady = 1'b1;
         @(negedge mclk);
         serOutReady = 1'b0;
         @(negedge mclk);
      end
   endtask : t_xfer_rd
   task automatic t_xfer_wr();
      int acc;
      acc = 0;
      serInValid = 1'b1;
      serInData  = 4'h9;
      for (int n = 0; n < 40; n++)
      begin
         if (serInReady === 1'b1)
            acc++;
         @(negedge mclk);
         serInData = 4'(acc) ^ 4'h9;
      end
      serInValid = 1'b0;
      check_count(acc, FIFO_DEPTH);
      cmd(CMD_SER_IN, 8'h00, 8'h20, 4'h0, 4'hf);
      repeat (80) @(negedge mclk);
      check_word({3'h0, serialIsInput}, 4'h1);
      rd_check(8'h00, 8'h20, pat(8'h00, 8'h20));
      cmd(CMD_XFER_WR, 8'h09, 8'h00, 4'h0, 4'hf);
      for (int k = 0; k < 4; k++)
         rd_check(8'h09, 8'(8'h20 + k), 4'(k) ^ 4'h9);
      rd_check(8'h09, 8'hfe, pat(8'h05, 8'hfe));
   endtask : t_xfer_wr
   initial
   begin
      {mclk, rst, cmdValid, serInValid, serOutReady} = 5'h08;
      {cmdOp, cmdRow, cmdCol, cmdData, cmdMask, serInData} = 31'h0;
      {randLast, shiftLast, fails, n_checks, cycles} = '0;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      repeat (2) @(negedge mclk);
      t_access();
      t_masked();
      t_refresh();
      t_xfer_rd();
      t_xfer_wr();
      close_out();
   end
endmodule : vdrp_host_bench
bind vdrp_host vdrp_host_properties #(.REF_INTERVAL(REF_INTERVAL)) i_props (
   .mclk(mclk), .rst(rst), .row_strobe_n(row_strobe_n),
   .col_strobe_n(col_strobe_n),
   .transfer_output_enable_n(transfer_output_enable_n),
   .mask_write_enable_n(mask_write_enable_n), .mux_addr(mux_addr),
   .rand_data_oe(rand_data_oe));
